// ===== vcmi2c_pkg.sv
// Constants, carriers and states of the two-wire slave port of the coil driver
// Summary of operation
// - Clock line is input only; data line is input and pull-low-only output.
// - Transfer is START, address with direction, register byte, data bytes, STOP.
// - Both lines stay high while the bus is idle.
// - Data falling while clock high is START; decoding restarts.
// - Data rising while clock high is STOP; bus becomes free.
// - One bit per clock pulse; data stays steady while clock is high.
// - Ninth pulse is acknowledge; receiver holds data low through it.
// - Master ends reads with not-acknowledge then STOP; port releases data before the not-acknowledge.
// - Bit after the 7-bit address is direction: low write, high read.
// - Respond only to first byte 0x1c (write) or 0x1d (read).
// - First byte after write address loads the register pointer.
// - Acknowledge the register byte only when it names a valid register.
// - Each write byte goes to the pointed register; pointer then increments; a full FIFO or a pointer past 0x08 refuses the byte.
// - Read is pointer write, repeated START, read address, then register contents.
// - Pointer increments after each sent byte; next byte only after acknowledge.
package vcmi2c_pkg;
   // Seven-bit bus address; with direction it reads 0x1c and 0x1d
   localparam logic [6:0] DEV_ADDR = 7'h0e;
   localparam logic DIR_WRITE = 1'b0;
   // Span of valid register pointers
   localparam logic [7:0] REG_FIRST = 8'h00;
   localparam logic [7:0] REG_LAST = 8'h08;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;
   localparam logic [7:0] PTR_RST = 8'h00;
   // Idle bus level seen by the synchronisers after reset
   localparam logic LINE_RST = 1'b1;
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } vcmi2c_wr_s;

   typedef enum logic [9:0] {
      ST_IDLE     = 10'h001,
      ST_ADDR     = 10'h002,
      ST_ADDR_ACK = 10'h004,
      ST_REG      = 10'h008,
      ST_REG_ACK  = 10'h010,
      ST_WDATA    = 10'h020,
      ST_WACK     = 10'h040,
      ST_RDATA    = 10'h080,
      ST_RACK     = 10'h100,
      ST_IGNORE   = 10'h200
   } vcmi2c_state_e;
endpackage

// ===== vcmi2c_slave.sv
// Two-wire slave port of the coil driver with its register write FIFO
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Write FIFO
// ****************************************
module vcmi2c_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
   logic full, empty, push, pop;

   // Extra pointer bit tells full from empty
   assign empty = (wptr_r == rptr_r);
   assign full = (wptr_r[AW-1:0] == rptr_r[AW-1:0]) && (wptr_r[AW] != rptr_r[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_r[rptr_r[AW-1:0]];
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;

   always_comb begin
      wptr_nxt = wptr_r;
      rptr_nxt = rptr_r;
      if (push) begin
         wptr_nxt = wptr_r + 1'b1;
      end
      if (pop) begin
         rptr_nxt = rptr_r + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
      end
   end

   // Storage has no reset; only written entries are ever read
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wptr_r[AW-1:0]] <= in_data;
      end
   end

   fifo_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (full |-> !empty) and (push && !pop |=> !empty))
      else $error("fifo flags inconsistent");
endmodule

// ****************************************
// Slave port
// ****************************************
module vcmi2c_slave
   import vcmi2c_pkg::*;
#(
   parameter logic [7:0] REG_LO = REG_FIRST,
   parameter logic [7:0] REG_HI = REG_LAST,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Serial lines
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // Register writes toward the register bank
   output logic wr_valid,
   input wire logic wr_ready,
   output vcmi2c_pkg::vcmi2c_wr_s wr_data,
   // Register readback
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data
);
   import vcmi2c_pkg::*;

   // ****************************************
   // Line synchronisers
   // ****************************************
   logic scl_meta_r, scl_sync_r, scl_prev_r;
   logic sda_meta_r, sda_sync_r, sda_prev_r;
   logic start, stop, scl_rise, scl_fall;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_meta_r <= LINE_RST;
         scl_sync_r <= LINE_RST;
         scl_prev_r <= LINE_RST;
         sda_meta_r <= LINE_RST;
         sda_sync_r <= LINE_RST;
         sda_prev_r <= LINE_RST;
      end else begin
         scl_meta_r <= scl_i;
         scl_sync_r <= scl_meta_r;
         scl_prev_r <= scl_sync_r;
         sda_meta_r <= sda_i;
         sda_sync_r <= sda_meta_r;
         sda_prev_r <= sda_sync_r;
      end
   end

   // Edges found from the second and third stages only
   assign scl_rise = scl_sync_r && !scl_prev_r;
   assign scl_fall = !scl_sync_r && scl_prev_r;
   assign start = scl_sync_r && scl_prev_r && sda_prev_r && !sda_sync_r;
   assign stop = scl_sync_r && scl_prev_r && !sda_prev_r && sda_sync_r;

   // ****************************************
   // Protocol state machine
   // ****************************************
   vcmi2c_state_e state_r, state_nxt;
   logic [3:0] bit_cnt_r, bit_cnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic oe_n_r, oe_n_nxt;
   logic rd_r, rd_nxt;
   logic ack_r, ack_nxt;
   logic fifo_in_ready, push;
   logic byte_done;
   vcmi2c_wr_s push_data;

   assign byte_done = scl_fall && (bit_cnt_r == BITS_PER_BYTE);
   assign push_data = '{addr: ptr_r, data: shift_r};

   always_comb begin
      state_nxt = state_r;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt = shift_r;
      ptr_nxt = ptr_r;
      oe_n_nxt = oe_n_r;
      rd_nxt = rd_r;
      ack_nxt = ack_r;
      push = 1'b0;
      if (start) begin
         // Also covers a repeated START in the middle of a transfer
         state_nxt = ST_ADDR;
         bit_cnt_nxt = BIT_CNT_RST;
         oe_n_nxt = 1'b1;
      end else if (stop) begin
         state_nxt = ST_IDLE;
         oe_n_nxt = 1'b1;
      end else begin
         case (state_r)
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (scl_rise) begin
                  shift_nxt = {shift_r[6:0], sda_sync_r};
                  bit_cnt_nxt = bit_cnt_r + 4'h1;
               end else if (byte_done) begin
                  bit_cnt_nxt = BIT_CNT_RST;
                  oe_n_nxt = 1'b0;
                  case (state_r)
                     ST_ADDR: begin
                        if (shift_r[7:1] == DEV_ADDR) begin
                           rd_nxt = (shift_r[0] != DIR_WRITE);
                           state_nxt = ST_ADDR_ACK;
                        end else begin
                           oe_n_nxt = 1'b1;
                           state_nxt = ST_IGNORE;
                        end
                     end
                     ST_REG: begin
                        ptr_nxt = shift_r;
                        if (shift_r >= REG_LO && shift_r <= REG_HI) begin
                           state_nxt = ST_REG_ACK;
                        end else begin
                           oe_n_nxt = 1'b1;
                           state_nxt = ST_IGNORE;
                        end
                     end
                     default: begin
                        // A full FIFO or a pointer run off the end refuses the byte
                        if (fifo_in_ready && ptr_r <= REG_HI) begin
                           push = 1'b1;
                           ptr_nxt = ptr_r + 8'h01;
                           state_nxt = ST_WACK;
                        end else begin
                           oe_n_nxt = 1'b1;
                           state_nxt = ST_IGNORE;
                        end
                     end
                  endcase
               end
            end
            ST_ADDR_ACK, ST_REG_ACK, ST_WACK: begin
               if (scl_fall) begin
                  oe_n_nxt = 1'b1;
                  if (state_r == ST_ADDR_ACK && rd_r) begin
                     shift_nxt = rd_data;
                     oe_n_nxt = rd_data[7];
                     state_nxt = ST_RDATA;
                  end else if (state_r == ST_ADDR_ACK) begin
                     state_nxt = ST_REG;
                  end else begin
                     state_nxt = ST_WDATA;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  bit_cnt_nxt = bit_cnt_r + 4'h1;
                  if (bit_cnt_r == BITS_PER_BYTE - 4'h1) begin
                     oe_n_nxt = 1'b1;
                     ptr_nxt = ptr_r + 8'h01;
                     state_nxt = ST_RACK;
                  end else begin
                     shift_nxt = {shift_r[6:0], 1'b0};
                     oe_n_nxt = shift_r[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  ack_nxt = !sda_sync_r;
               end else if (scl_fall) begin
                  bit_cnt_nxt = BIT_CNT_RST;
                  if (ack_r) begin
                     shift_nxt = rd_data;
                     oe_n_nxt = rd_data[7];
                     state_nxt = ST_RDATA;
                  end else begin
                     state_nxt = ST_IGNORE;
                  end
               end
            end
            ST_IDLE, ST_IGNORE: begin
               oe_n_nxt = 1'b1;
            end
            default: begin
               state_nxt = ST_IDLE;
               oe_n_nxt = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= BIT_CNT_RST;
         shift_r <= '0;
         ptr_r <= PTR_RST;
         oe_n_r <= 1'b1;
         rd_r <= 1'b0;
         ack_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r <= shift_nxt;
         ptr_r <= ptr_nxt;
         oe_n_r <= oe_n_nxt;
         rd_r <= rd_nxt;
         ack_r <= ack_nxt;
      end
   end

   // The port only ever pulls low; the clock line has no driver here
   assign sda_o = 1'b0;
   assign sda_oe_n = oe_n_r;
   // Readback follows the pointer; writes still in the FIFO are not yet visible
   assign rd_addr = ptr_r;

   // ****************************************
   // Write buffer
   // ****************************************
   vcmi2c_fifo #(
      .WIDTH($bits(vcmi2c_wr_s)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_data)
   );

   // ****************************************
   // Checks
   // ****************************************
   sequence byte_end_s;
      byte_done && !start && !stop;
   endsequence

   sequence ack_drive_s;
      !sda_oe_n;
   endsequence

   start_decode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      start |=> (state_r == ST_ADDR) && (bit_cnt_r == BIT_CNT_RST) && sda_oe_n)
      else $error("start not followed by address phase");

   stop_free_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      stop |=> (state_r == ST_IDLE) && sda_oe_n)
      else $error("stop did not free the bus");

   idle_release_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_r == ST_IDLE || state_r == ST_IGNORE) |-> sda_oe_n)
      else $error("data driven while bus idle");

   addr_match_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_r == ST_ADDR) ##0 byte_end_s |=>
         if (shift_r[7:1] == DEV_ADDR) (ack_drive_s and (state_r == ST_ADDR_ACK) and (rd_r == shift_r[0]))
         else (sda_oe_n && state_r == ST_IGNORE))
      else $error("address acknowledge wrong");

   bad_reg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_r == ST_REG) ##0 byte_end_s ##0 (shift_r > REG_HI || shift_r < REG_LO) |=>
         (state_r == ST_IGNORE) && sda_oe_n && (ptr_r == $past(shift_r)))
      else $error("invalid register acknowledged");

   write_push_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      push |-> (state_r == ST_WDATA) && byte_done ##1 (ptr_r == $past(ptr_r) + 8'h01) && !sda_oe_n)
      else $error("write byte not stored and counted");

   hold_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (scl_sync_r && scl_prev_r && !start && !stop) |=> $stable(sda_oe_n))
      else $error("data changed while clock high");

   ack_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_r == ST_REG_ACK && scl_rise) |-> ack_drive_s ##1 (ack_drive_s or (scl_fall || start || stop)))
      else $error("acknowledge released early");

   read_next_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_r == ST_RACK && scl_fall && !start && !stop) |=>
         ($past(ack_r) ? (state_r == ST_RDATA && shift_r == $past(rd_data))
                       : (state_r == ST_IGNORE && sda_oe_n)))
      else $error("read continuation wrong");

   read_release_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_r == ST_RDATA && scl_fall && bit_cnt_r == 4'h7 && !start && !stop) |=>
         sda_oe_n && (state_r == ST_RACK) && (ptr_r == $past(ptr_r) + 8'h01))
      else $error("no release for master acknowledge");
endmodule

`default_nettype wire

// ===== vcmi2c_mst.sv
// Behavioural bus master that drives the two-wire link of the coil driver port
`timescale 1ns/1ns
`default_nettype none

module vcmi2c_mst (
   // Serial lines
   output logic scl,
   output logic sda_oe_n,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_oe_n = 1'b1;
   end

   // ****************************************
   // Bit and frame tasks
   // ****************************************
   // Data moves four core clocks after the clock fall, so the port has seen the fall first
   task automatic bit_x(input logic b, output logic s);
      #160 sda_oe_n = b;
      #40 scl = 1'b1;
      #120 s = sda;
      scl = 1'b0;
   endtask

   task automatic start_c();
      if (scl === 1'b0) begin
         #160 sda_oe_n = 1'b1;
         #40 scl = 1'b1;
      end
      #120 sda_oe_n = 1'b0;
      #120 scl = 1'b0;
   endtask

   task automatic stop_c();
      #160 sda_oe_n = 1'b0;
      #40 scl = 1'b1;
      #120 sda_oe_n = 1'b1;
      #160;
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], s);
      end
      bit_x(1'b1, s);
      ack = ~s;
   endtask

   // The last byte of a read is answered with a release so the port gives up the line
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         d[i] = s;
      end
      bit_x(~ack, s);
   endtask
endmodule

`default_nettype wire

// ===== vcm_driver_i2c_slave_port_tb_top.sv
// Self-checking testbench of the two-wire slave port with its write FIFO
`timescale 1ns/1ns
`default_nettype none

module vcm_driver_i2c_slave_port_tb_top;
   import vcmi2c_pkg::*;

   logic core_clk = 1'b0;
   logic rst_n;
   logic scl;
   logic m_oe_n;
   logic sda_w;
   logic sda_o;
   logic sda_oe_n;
   logic wr_valid;
   logic wr_ready;
   vcmi2c_wr_s wr_data;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] regs [0:8];
   logic [15:0] got_q [$];
   int error_cnt = 0;
   int checked = 0;

   always #20 core_clk = ~core_clk;

   // Open-drain wire with pull-up: either party pulling low wins
   assign sda_w = m_oe_n & (sda_oe_n | sda_o);
   assign rd_data = (rd_addr <= 8'h08) ? regs[rd_addr[3:0]] : 8'h00;

   vcmi2c_slave vcmi2c_slave_i (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .scl_i(scl),
      .sda_i(sda_w),
      .sda_o(sda_o),
      .sda_oe_n(sda_oe_n),
      .wr_valid(wr_valid),
      .wr_ready(wr_ready),
      .wr_data(wr_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   vcmi2c_mst vcmi2c_mst_i (
      .scl(scl),
      .sda_oe_n(m_oe_n),
      .sda(sda_w)
   );

   // Register bank stand-in consuming the write FIFO
   always @(posedge core_clk) begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
         got_q.push_back(wr_data);
         if (wr_data.addr <= 8'h08) begin
            regs[wr_data.addr[3:0]] <= wr_data.data;
         end
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic send(input string nm, input logic [7:0] d, input logic exp_ack);
      logic a;
      vcmi2c_mst_i.wr_byte(d, a);
      chk(nm, 16'(a), 16'(exp_ack));
   endtask

   task automatic final_report();
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk("oe_n idle", 16'(sda_oe_n), 16'h0001);
      chk("sda_o low", 16'(sda_o), 16'h0000);
      chk("wr_valid idle", 16'(wr_valid), 16'h0000);
      chk("ptr idle", 16'(rd_addr), 16'h0000);
   endtask

   task automatic t_write();
      got_q.delete();
      vcmi2c_mst_i.start_c();
      send("wr addr", 8'h1c, 1'b1);
      send("reg", 8'h03, 1'b1);
      send("d0", 8'ha5, 1'b1);
      send("d1", 8'h5a, 1'b1);
      send("d2", 8'hc3, 1'b1);
      vcmi2c_mst_i.stop_c();
      repeat (4) @(negedge core_clk);
      chk("wr count", 16'(got_q.size()), 16'h0003);
      chk("wr0", got_q[0], 16'h03a5);
      chk("wr1", got_q[1], 16'h045a);
      chk("wr2", got_q[2], 16'h05c3);
      chk("ptr after", 16'(rd_addr), 16'h0006);
      chk("oe_n stop", 16'(sda_oe_n), 16'h0001);
   endtask

   task automatic t_read();
      logic [7:0] d;
      vcmi2c_mst_i.start_c();
      send("wr addr", 8'h1c, 1'b1);
      send("reg", 8'h04, 1'b1);
      vcmi2c_mst_i.start_c();
      send("rd addr", 8'h1d, 1'b1);
      vcmi2c_mst_i.rd_byte(1'b1, d);
      chk("rd0", 16'(d), 16'h005a);
      vcmi2c_mst_i.rd_byte(1'b1, d);
      chk("rd1", 16'(d), 16'h00c3);
      vcmi2c_mst_i.rd_byte(1'b0, d);
      chk("rd2", 16'(d), 16'h0096);
      repeat (2) @(negedge core_clk);
      chk("oe_n nack", 16'(sda_oe_n), 16'h0001);
      vcmi2c_mst_i.stop_c();
      chk("ptr rd", 16'(rd_addr), 16'h0007);
      // Direct read resumes from the pointer left behind
      vcmi2c_mst_i.start_c();
      send("rd addr", 8'h1d, 1'b1);
      vcmi2c_mst_i.rd_byte(1'b0, d);
      chk("rd direct", 16'(d), 16'h0097);
      vcmi2c_mst_i.stop_c();
   endtask

   task automatic t_refuse();
      got_q.delete();
      vcmi2c_mst_i.start_c();
      send("bad addr", 8'h3a, 1'b0);
      send("ignored", 8'h1c, 1'b0);
      vcmi2c_mst_i.stop_c();
      vcmi2c_mst_i.start_c();
      send("wr addr", 8'h1c, 1'b1);
      send("bad reg", 8'h09, 1'b0);
      send("after bad", 8'h77, 1'b0);
      vcmi2c_mst_i.stop_c();
      vcmi2c_mst_i.start_c();
      send("wr addr", 8'h1c, 1'b1);
      send("last reg", 8'h08, 1'b1);
      send("last data", 8'h11, 1'b1);
      send("past end", 8'h22, 1'b0);
      vcmi2c_mst_i.stop_c();
      repeat (4) @(negedge core_clk);
      chk("refused count", 16'(got_q.size()), 16'h0001);
      chk("last write", got_q[0], 16'h0811);
   endtask

   task automatic t_fifo();
      got_q.delete();
      wr_ready = 1'b0;
      for (int t = 0; t < 2; t++) begin
         vcmi2c_mst_i.start_c();
         send("wr addr", 8'h1c, 1'b1);
         send("reg", 8'h00, 1'b1);
         for (int i = 0; i < 8; i++) begin
            send("fill", 8'(8'h40 + 8 * t + i), 1'b1);
         end
         vcmi2c_mst_i.stop_c();
      end
      chk("full valid", 16'(wr_valid), 16'h0001);
      vcmi2c_mst_i.start_c();
      send("wr addr", 8'h1c, 1'b1);
      send("reg", 8'h00, 1'b1);
      send("full", 8'hee, 1'b0);
      vcmi2c_mst_i.stop_c();
      wr_ready = 1'b1;
      repeat (24) @(negedge core_clk);
      chk("drained", 16'(wr_valid), 16'h0000);
      chk("drain count", 16'(got_q.size()), 16'h0010);
      for (int k = 0; k < 16; k++) begin
         chk("fifo entry", got_q[k], {8'(k % 8), 8'(8'h40 + k)});
      end
   endtask

   initial begin
      rst_n = 1'b0;
      wr_ready = 1'b1;
      for (int i = 0; i < 9; i++) begin
         regs[i] = 8'(8'h90 + i);
      end
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      t_reset();
      t_write();
      t_read();
      t_refuse();
      t_fifo();
      final_report();
   end

   // About 45 bytes of 2.9 us each fit well inside this span
   initial begin
      #1000000;
      error_cnt++;
      final_report();
   end
endmodule

`default_nettype wire
